//--- core/fpo_pkg.sv
package fpo_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL_OFS   = 12'h600;
  localparam logic [11:0] PIN_OFS    = 12'h604;
  localparam logic [11:0] STATUS_OFS = 12'h608;
  localparam logic [11:0] MODT_OFS   = 12'h610;
  // panel_control fields
  localparam int POLY_BIT  = 19;
  localparam int FIRST_BIT = 20;
  localparam int ALL_BIT   = 21;
  localparam int TEST_LSB  = 28;
  // panel_pin_control fields
  localparam int PIN_DIS_BIT = 0;
  localparam int DE_SEL_BIT  = 2;
  localparam int MOD_EN_BIT  = 3;
  localparam int PWM_EN_BIT  = 5;
  // modulation_timing_reg field
  localparam int MOD_LSB = 24;
  // status fields
  localparam int STAT_FIFO_LSB = 16;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PIN_RST  = 32'h0000_0000;
  localparam logic [7:0]  MODT_RST = 8'h00;
  // poly-Si divide and forced first lines
  localparam int POLY_DIV    = 3;
  localparam int FORCE_LINES = 3;
  localparam int COLOR_W     = 6;
  // one pixel from the frame source
  typedef struct packed {
    logic [COLOR_W-1:0] red;
    logic [COLOR_W-1:0] green;
    logic [COLOR_W-1:0] blue;
  } fpo_pixel_type;
  // colour chosen for a line in poly-Si mode
  typedef enum {FPO_RED, FPO_GREEN, FPO_BLUE} fpo_color_type;
endpackage

//--- core/fpo_top.sv
// How it works
// - Poly-Si mode divides the shift clock by 3, sends one colour per line and toggles modulation every 3 lines.
// - Poly-Si with the first-line bit drives the first red, green and blue lines as all ones.
// - Poly-Si with the all-lines bit drives every display line as all ones, over the first-line bit.
// - Both forcing bits do nothing unless the poly-Si bit is set.
// - Each of the four test bits enables a factory test mode and stays zero in normal use.
// - Pin disable drives all panel data and control outputs low except the PWM clock.
// - Display enable pin carries composite enable when its select is 0, horizontal when 1.
// - Modulation is generated only while enabled, its period set by the modulation timing field outside poly-Si mode.
// - Modulation enable works for any panel type.
// - The PWM clock runs only while its enable is set.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module fpo_fifo
#(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
)
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic [WIDTH-1:0]   in_data,
  input  wire logic               in_valid,
  output logic                    in_ready,
  output logic [WIDTH-1:0]        out_data,
  output logic                    out_valid,
  input  wire logic               out_ready,
  output logic [$clog2(DEPTH):0]  count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // handshakes and flags
  assign in_ready  = count_reg != (AW+1)'(DEPTH);
  assign out_valid = count_reg != '0;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr_reg];
  assign count     = count_reg;

  // storage
  always_ff @(posedge pclk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  // pointers and fill level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule

module fpo_top
#(
  parameter int HW         = 10,
  parameter int H_ACT      = 320,
  parameter int H_TOT      = 400,
  parameter int V_ACT      = 240,
  parameter int V_TOT      = 250,
  parameter int PWM_DIV    = 16,
  parameter int FIFO_DEPTH = 8
)
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire fpo_pkg::fpo_pixel_type pix_data,
  input  wire logic                  pix_valid,
  output logic                       pix_ready,
  output logic [23:0]                panel_data_bus,
  output logic                       panel_shift_clock,
  output logic                       panel_display_enable_pin,
  output logic                       panel_horizontal_sync,
  output logic                       panel_vertical_sync,
  output logic                       panel_ac_modulation,
  output logic                       panel_line_clock,
  output logic                       panel_pwm_clock,
  output logic [3:0]                 test_mode
);
  localparam int FW = $clog2(FIFO_DEPTH) + 1;
  localparam int CW = fpo_pkg::COLOR_W;
  logic [31:0]   ctrl_reg;
  logic [31:0]   pin_reg;
  logic [7:0]    modt_reg;
  logic [31:0]   prdata_reg;
  logic [31:0]   rd_next;
  logic          hit;
  logic          poly;
  logic          pin_dis;
  logic          force_all;
  logic          force_first;
  logic [1:0]    div_reg;
  logic          tick;
  logic [HW-1:0] hcnt_reg;
  logic [HW-1:0] vcnt_reg;
  logic          line_end;
  logic          h_act;
  logic          v_act;
  logic          active;
  fpo_pkg::fpo_pixel_type fifo_data;
  logic          fifo_valid;
  logic          fifo_pop;
  logic [FW-1:0] fifo_cnt;
  fpo_pkg::fpo_color_type color_reg;
  fpo_pkg::fpo_pixel_type pix_sel;
  logic [23:0]   data_next;
  logic [7:0]    modcnt_reg;
  logic          mod_reg;
  logic [15:0]   pwmcnt_reg;
  logic          pwm_reg;
  logic          sclk_reg;

  // apb decode, zero-wait slave
  assign hit = paddr == fpo_pkg::CTRL_OFS || paddr == fpo_pkg::PIN_OFS
            || paddr == fpo_pkg::STATUS_OFS || paddr == fpo_pkg::MODT_OFS;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_reg;

  // register writes; reserved bits never stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= fpo_pkg::CTRL_RST;
      pin_reg  <= fpo_pkg::PIN_RST;
      modt_reg <= fpo_pkg::MODT_RST;
    end
    else if (psel && penable && pwrite)
    begin
      if (paddr == fpo_pkg::CTRL_OFS)
        ctrl_reg <= pwdata & 32'hF038_0000;
      if (paddr == fpo_pkg::PIN_OFS)
        pin_reg <= pwdata & 32'h0000_002D;
      if (paddr == fpo_pkg::MODT_OFS)
        modt_reg <= pwdata[fpo_pkg::MOD_LSB +: 8];
    end
  end

  // read mux
  always_comb
  begin
    rd_next = 32'h0000_0000;
    case (paddr)
      fpo_pkg::CTRL_OFS:   rd_next = ctrl_reg;
      fpo_pkg::PIN_OFS:    rd_next = pin_reg;
      fpo_pkg::MODT_OFS:   rd_next = {modt_reg, 24'h00_0000};
      fpo_pkg::STATUS_OFS: rd_next = 32'(vcnt_reg)
                           | (32'(fifo_cnt) << fpo_pkg::STAT_FIFO_LSB);
      default:             rd_next = 32'h0000_0000;
    endcase
  end

  // read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_reg <= rd_next;
  end

  // control decode
  assign poly        = ctrl_reg[fpo_pkg::POLY_BIT];
  assign pin_dis     = pin_reg[fpo_pkg::PIN_DIS_BIT];
  assign force_all   = poly & ctrl_reg[fpo_pkg::ALL_BIT];
  assign force_first = poly & ctrl_reg[fpo_pkg::FIRST_BIT]
                     & (vcnt_reg < HW'(fpo_pkg::FORCE_LINES));
  assign test_mode   = ctrl_reg[fpo_pkg::TEST_LSB +: 4];

  // pixel tick, every third clock in poly-Si mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_reg <= 2'h0;
    else if (!poly || div_reg == 2'(fpo_pkg::POLY_DIV - 1))
      div_reg <= 2'h0;
    else
      div_reg <= div_reg + 2'h1;
  end
  assign tick = !poly || div_reg == 2'(fpo_pkg::POLY_DIV - 1);

  // raster counters
  assign line_end = tick && hcnt_reg == HW'(H_TOT - 1);
  assign h_act    = hcnt_reg < HW'(H_ACT);
  assign v_act    = vcnt_reg < HW'(V_ACT);
  assign active   = h_act & v_act;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hcnt_reg <= '0;
      vcnt_reg <= '0;
    end
    else if (tick)
    begin
      hcnt_reg <= line_end ? '0 : hcnt_reg + 1'b1;
      if (line_end)
        vcnt_reg <= (vcnt_reg == HW'(V_TOT - 1)) ? '0 : vcnt_reg + 1'b1;
    end
  end

  // line colour sequence for poly-Si mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      color_reg <= fpo_pkg::FPO_RED;
    else if (line_end && vcnt_reg == HW'(V_TOT - 1))
      color_reg <= fpo_pkg::FPO_RED;
    else if (line_end)
      case (color_reg)
        fpo_pkg::FPO_RED:   color_reg <= fpo_pkg::FPO_GREEN;
        fpo_pkg::FPO_GREEN: color_reg <= fpo_pkg::FPO_BLUE;
        default:            color_reg <= fpo_pkg::FPO_RED;
      endcase
  end

  // line buffer in front of the panel
  assign fifo_pop = tick & active;
  fpo_fifo #(.WIDTH($bits(fpo_pkg::fpo_pixel_type)), .DEPTH(FIFO_DEPTH))
    u_fifo
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_data   (pix_data),
    .in_valid  (pix_valid),
    .in_ready  (pix_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .count     (fifo_cnt)
  );

  // pixel select: underrun shows black, poly-Si keeps one colour
  always_comb
  begin
    pix_sel = fifo_valid ? fifo_data : '0;
    if (poly)
    begin
      if (color_reg != fpo_pkg::FPO_RED)
        pix_sel.red = '0;
      if (color_reg != fpo_pkg::FPO_GREEN)
        pix_sel.green = '0;
      if (color_reg != fpo_pkg::FPO_BLUE)
        pix_sel.blue = '0;
    end
    if (force_all || force_first)
      pix_sel = '1;
    data_next = {pix_sel.red, 2'b00, pix_sel.green, 2'b00,
                 pix_sel.blue, 2'b00};
    if (!active)
      data_next = 24'h00_0000;
  end

  // panel output flops, all low while pins disabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      panel_data_bus           <= 24'h00_0000;
      sclk_reg                 <= 1'b0;
      panel_display_enable_pin <= 1'b0;
      panel_horizontal_sync    <= 1'b0;
      panel_vertical_sync      <= 1'b0;
      panel_line_clock         <= 1'b0;
    end
    else if (pin_dis)
    begin
      panel_data_bus           <= 24'h00_0000;
      sclk_reg                 <= 1'b0;
      panel_display_enable_pin <= 1'b0;
      panel_horizontal_sync    <= 1'b0;
      panel_vertical_sync      <= 1'b0;
      panel_line_clock         <= 1'b0;
    end
    else if (tick)
    begin
      panel_data_bus <= data_next;
      sclk_reg       <= ~sclk_reg;
      panel_display_enable_pin <= pin_reg[fpo_pkg::DE_SEL_BIT]
                                  ? h_act : active;
      panel_horizontal_sync <= hcnt_reg >= HW'(H_ACT + 2)
                            && hcnt_reg < HW'(H_ACT + 4);
      panel_vertical_sync   <= vcnt_reg == HW'(V_ACT + 1);
      panel_line_clock      <= hcnt_reg == HW'(H_ACT);
    end
  end
  assign panel_shift_clock = sclk_reg;

  // ac modulation, any panel type
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      modcnt_reg <= 8'h00;
      mod_reg    <= 1'b0;
    end
    else if (!pin_reg[fpo_pkg::MOD_EN_BIT])
    begin
      modcnt_reg <= 8'h00;
      mod_reg    <= 1'b0;
    end
    else if (line_end)
    begin
      if (modcnt_reg >= (poly ? 8'(fpo_pkg::POLY_DIV - 1) : modt_reg))
      begin
        modcnt_reg <= 8'h00;
        mod_reg    <= ~mod_reg;
      end
      else
        modcnt_reg <= modcnt_reg + 8'h01;
    end
  end
  assign panel_ac_modulation = mod_reg & ~pin_dis;

  // pwm clock divider
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwmcnt_reg <= 16'h0000;
      pwm_reg    <= 1'b0;
    end
    else if (!pin_reg[fpo_pkg::PWM_EN_BIT])
    begin
      pwmcnt_reg <= 16'h0000;
      pwm_reg    <= 1'b0;
    end
    else if (pwmcnt_reg == 16'(PWM_DIV - 1))
    begin
      pwmcnt_reg <= 16'h0000;
      pwm_reg    <= ~pwm_reg;
    end
    else
      pwmcnt_reg <= pwmcnt_reg + 16'h0001;
  end
  assign panel_pwm_clock = pwm_reg;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PIN_DISABLE: assert property (
    pin_dis |=> panel_data_bus == 24'h00_0000 && !panel_shift_clock
      && !panel_display_enable_pin && !panel_horizontal_sync
      && !panel_vertical_sync && !panel_line_clock)
    else $error("panel pins active while disabled");
  AST_MOD_PIN_OFF: assert property (
    pin_dis |-> !panel_ac_modulation)
    else $error("modulation active while pins disabled");
  AST_FORCE_ALL: assert property (
    tick && active && poly && ctrl_reg[fpo_pkg::ALL_BIT] && !pin_dis
      |=> panel_data_bus == 24'hFC_FCFC)
    else $error("all-lines forcing missing");
  AST_FIRST_LINES: assert property (
    tick && active && poly && ctrl_reg[fpo_pkg::FIRST_BIT] && !pin_dis
      && vcnt_reg < HW'(fpo_pkg::FORCE_LINES)
      |=> panel_data_bus == 24'hFC_FCFC)
    else $error("first-line forcing missing");
  AST_NO_POLY_NO_FORCE: assert property (
    tick && active && !poly && !fifo_valid && !pin_dis
      |=> panel_data_bus == 24'h00_0000)
    else $error("forcing without poly-Si mode");
  AST_POLY_DIVIDE: assert property (
    poly && tick ##1 poly [*3] |-> tick && !$past(tick)
      && !$past(tick, 2))
    else $error("poly-Si tick not divided by three");
  AST_DE_SELECT: assert property (
    tick && !pin_dis |=> panel_display_enable_pin
      == ($past(pin_reg[fpo_pkg::DE_SEL_BIT]) ? $past(h_act)
          : $past(active)))
    else $error("display enable source wrong");
  AST_MOD_OFF: assert property (
    !pin_reg[fpo_pkg::MOD_EN_BIT] |=> !panel_ac_modulation [*2])
    else $error("modulation while disabled");
  AST_PWM_OFF: assert property (
    !pin_reg[fpo_pkg::PWM_EN_BIT] |=> !panel_pwm_clock)
    else $error("pwm clock while disabled");
  AST_TEST_BITS: assert property (
    psel && penable && pwrite && paddr == fpo_pkg::CTRL_OFS
      |=> test_mode == $past(pwdata[fpo_pkg::TEST_LSB +: 4]))
    else $error("test mode bits not taken");
endmodule
`default_nettype wire

//--- test/fpo_panel_model.sv
`timescale 1ns/1ns
`default_nettype none
// passive panel: counts what arrives on its pins between clears
module fpo_panel_model
(
  input  wire logic        pclk,
  input  wire logic        clr,
  input  wire logic [23:0] data,
  input  wire logic        sclk,
  input  wire logic        de,
  input  wire logic        hs,
  input  wire logic        vs,
  input  wire logic        mods,
  input  wire logic        lclk,
  input  wire logic        pwm,
  output logic [15:0]      sclk_tgl,
  output logic [15:0]      mod_tgl,
  output logic [15:0]      pwm_tgl,
  output logic [15:0]      de_cnt,
  output logic [15:0]      data_cnt,
  output logic [15:0]      ctl_cnt,
  output logic [15:0]      hs_cnt,
  output logic [15:0]      vs_cnt,
  output logic [15:0]      lc_cnt
);
  logic sclk_q;
  logic mod_q;
  logic pwm_q;
  // last levels, kept through clears for edge counting
  always_ff @(posedge pclk)
  begin
    sclk_q <= sclk;
    mod_q  <= mods;
    pwm_q  <= pwm;
  end
  // event counters, zeroed while clr is high
  always_ff @(posedge pclk)
  begin
    if (clr)
    begin
      sclk_tgl <= 16'h0000;
      mod_tgl  <= 16'h0000;
      pwm_tgl  <= 16'h0000;
      de_cnt   <= 16'h0000;
      data_cnt <= 16'h0000;
      ctl_cnt  <= 16'h0000;
      hs_cnt   <= 16'h0000;
      vs_cnt   <= 16'h0000;
      lc_cnt   <= 16'h0000;
    end
    else
    begin
      sclk_tgl <= sclk_tgl + {15'h0000, sclk ^ sclk_q};
      mod_tgl  <= mod_tgl + {15'h0000, mods ^ mod_q};
      pwm_tgl  <= pwm_tgl + {15'h0000, pwm ^ pwm_q};
      de_cnt   <= de_cnt + {15'h0000, de};
      data_cnt <= data_cnt + {15'h0000, |data};
      ctl_cnt  <= ctl_cnt + {15'h0000, sclk | de | hs | vs | mods | lclk};
      hs_cnt   <= hs_cnt + {15'h0000, hs};
      vs_cnt   <= vs_cnt + {15'h0000, vs};
      lc_cnt   <= lc_cnt + {15'h0000, lclk};
    end
  end
endmodule
`default_nettype wire

//--- test/flat_panel_output_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
module flat_panel_output_control_bench;
  localparam logic [11:0] BAD_OFS = 12'h7F0;
  logic                   pclk    = 1'b0;
  logic                   presetn = 1'b0;
  logic                   psel    = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite  = 1'b0;
  logic [11:0]            paddr   = 12'h000;
  logic [31:0]            pwdata  = 32'h0000_0000;
  fpo_pkg::fpo_pixel_type pix     = '0;
  logic                   pix_valid = 1'b1;
  logic                   clr     = 1'b1;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   pix_ready;
  logic [23:0]            pdb;
  logic                   sclk, de, hs, vs, mods, lclk, pwm;
  logic [3:0]             tmode;
  logic [15:0]            sclk_tgl, mod_tgl, pwm_tgl;
  logic [15:0]            de_cnt, data_cnt, ctl_cnt;
  logic [15:0]            hs_cnt, vs_cnt, lc_cnt;
  logic [31:0]            rd;
  logic                   err;
  int                     error_cnt   = 0;
  int                     checks_done = 0;

  // clock 4 ns
  always #2 pclk = ~pclk;

  fpo_top #(.H_ACT(8), .H_TOT(12), .V_ACT(4), .V_TOT(6),
            .PWM_DIV(4)) uut
  (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pix_data(pix),
   .pix_valid(pix_valid), .pix_ready(pix_ready), .panel_data_bus(pdb),
   .panel_shift_clock(sclk), .panel_display_enable_pin(de),
   .panel_horizontal_sync(hs), .panel_vertical_sync(vs),
   .panel_ac_modulation(mods), .panel_line_clock(lclk),
   .panel_pwm_clock(pwm), .test_mode(tmode));

  fpo_panel_model panel
  (.pclk(pclk), .clr(clr), .data(pdb), .sclk(sclk), .de(de), .hs(hs),
   .vs(vs), .mods(mods), .lclk(lclk), .pwm(pwm), .sclk_tgl(sclk_tgl),
   .mod_tgl(mod_tgl), .pwm_tgl(pwm_tgl), .de_cnt(de_cnt),
   .data_cnt(data_cnt), .ctl_cnt(ctl_cnt), .hs_cnt(hs_cnt),
   .vs_cnt(vs_cnt), .lc_cnt(lc_cnt));

  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      error_cnt++;
      end_sim();
    end
  endtask

  // clear the panel counters, let a config change settle, count n cycles
  task automatic run(input int n);
    @(posedge pclk);
    clr <= 1'b1;
    repeat (3) @(posedge pclk);
    clr <= 1'b0;
    repeat (n) @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk); // last counted edge has landed
  endtask

  task automatic t_regs();
    apb(1'b0, fpo_pkg::CTRL_OFS, 32'h0);
    check(rd, fpo_pkg::CTRL_RST);
    check({28'h0, tmode}, 32'h0);
    apb(1'b0, fpo_pkg::PIN_OFS, 32'h0);
    check(rd, fpo_pkg::PIN_RST);
    apb(1'b1, fpo_pkg::CTRL_OFS, 32'hFFFF_FFFF);
    apb(1'b0, fpo_pkg::CTRL_OFS, 32'h0);
    check(rd, 32'hF038_0000);
    apb(1'b1, fpo_pkg::PIN_OFS, 32'hFFFF_FFFF);
    apb(1'b0, fpo_pkg::PIN_OFS, 32'h0);
    check(rd, 32'h0000_002D);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, fpo_pkg::CTRL_OFS, 32'h1000_0000 << i);
      @(posedge pclk);
      check({28'h0, tmode}, 32'h1 << i);
    end
    apb(1'b1, BAD_OFS, 32'hFFFF_FFFF);
    check({31'h0, err}, 32'h1);
    apb(1'b0, BAD_OFS, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, fpo_pkg::CTRL_OFS, 32'h0);
    apb(1'b1, fpo_pkg::PIN_OFS, 32'h0);
    $display("test registers done");
  endtask

  task automatic t_clocks();
    run(300);
    check({16'h0, sclk_tgl}, 32'd300);
    run(80);
    check({16'h0, pwm_tgl}, 32'd0);
    apb(1'b1, fpo_pkg::PIN_OFS, 32'h0000_0020);
    run(80);
    check({16'h0, pwm_tgl}, 32'd20);
    apb(1'b1, fpo_pkg::PIN_OFS, 32'h0);
    run(80);
    check({16'h0, pwm_tgl}, 32'd0);
    run(72);
    check({16'h0, de_cnt}, 32'd32);
    check({16'h0, hs_cnt}, 32'd12);
    check({16'h0, vs_cnt}, 32'd12);
    check({16'h0, lc_cnt}, 32'd6);
    apb(1'b1, fpo_pkg::PIN_OFS, 32'h0000_0004);
    run(72);
    check({31'h0, de_cnt > 16'd32}, 32'h1);
    $display("test clocks done");
  endtask

  task automatic t_mod();
    apb(1'b1, fpo_pkg::MODT_OFS, 32'h0100_0000);
    run(240);
    check({16'h0, mod_tgl}, 32'd0);
    apb(1'b1, fpo_pkg::CTRL_OFS, 32'h0000_0004);
    apb(1'b1, fpo_pkg::PIN_OFS, 32'h0000_0008);
    run(240);
    check({16'h0, mod_tgl}, 32'd10);
    apb(1'b1, fpo_pkg::CTRL_OFS, 32'h0008_0000);
    run(432);
    check({16'h0, mod_tgl}, 32'd4);
    run(300);
    check({16'h0, sclk_tgl}, 32'd100);
    $display("test modulation done");
  endtask

  task automatic t_force();
    logic [31:0] cfg [4] = '{32'h0020_0000, 32'h0028_0000,
                             32'h0018_0000, 32'h0008_0000};
    logic        hit [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    apb(1'b1, fpo_pkg::PIN_OFS, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, fpo_pkg::CTRL_OFS, cfg[i]);
      run(432);
      check({31'h0, data_cnt != 16'h0}, {31'h0, hit[i]});
    end
    $display("test forcing done");
  endtask

  task automatic t_pins();
    pix <= '1;
    apb(1'b1, fpo_pkg::CTRL_OFS, 32'h0);
    apb(1'b1, fpo_pkg::PIN_OFS, 32'h0000_0009);
    run(144);
    check({16'h0, data_cnt}, 32'd0);
    check({16'h0, ctl_cnt}, 32'd0);
    apb(1'b1, fpo_pkg::PIN_OFS, 32'h0000_0008);
    run(144);
    check({31'h0, data_cnt != 16'h0}, 32'h1);
    check({31'h0, ctl_cnt != 16'h0}, 32'h1);
    $display("test pin disable done");
  endtask

  task automatic t_fifo();
    int n;
    apb(1'b1, fpo_pkg::CTRL_OFS, 32'h0008_0000);
    n = 0;
    while (pix_ready !== 1'b0 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, n < 100}, 32'h1);
    pix_valid <= 1'b0;
    run(432);
    check({31'h0, pix_ready}, 32'h1);
    apb(1'b0, fpo_pkg::STATUS_OFS, 32'h0);
    check({28'h0, rd[19:16]}, 32'h0);
    $display("test fifo done");
  endtask

  // main sequence
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_clocks();
    t_mod();
    t_force();
    t_pins();
    t_fifo();
    end_sim();
  end
endmodule
`default_nettype wire
